// ### verilog/pmaddr_pkg.sv
package pmaddr_pkg;

  // ==========================================================================
  // Widths and vectors
  localparam int          PMADDR_PC_W      = 13;
  localparam int          PMADDR_IMPL_W    = 12;
  localparam int          PMADDR_WORD_W    = 14;
  localparam int          PMADDR_DEPTH     = 4096;
  localparam int          PMADDR_STACK_N   = 8;
  localparam int          PMADDR_SP_W      = 3;
  localparam int          PMADDR_LIT_W     = 8;
  localparam logic [12:0] PMADDR_RESET_VEC = 13'h0000;
  localparam logic [12:0] PMADDR_INT_VEC   = 13'h0004;
  localparam logic [12:0] PMADDR_STEP      = 13'h0001;
  localparam logic [2:0]  PMADDR_SP_ONE    = 3'h1;

  // ==========================================================================
  // Control carried from the core
  typedef enum logic [2:0] {
    PMADDR_OP_HOLD = 3'b000,
    PMADDR_OP_NEXT = 3'b001,
    PMADDR_OP_JUMP = 3'b010,
    PMADDR_OP_CALL = 3'b011,
    PMADDR_OP_RET  = 3'b100,
    PMADDR_OP_RETL = 3'b101
  } pmaddr_op_t;

  typedef struct packed {
    pmaddr_op_t  op;
    logic        irq_take;
    logic [12:0] target;
    logic [7:0]  literal;
  } pmaddr_ctrl_t;

  typedef struct packed {
    logic        rd_en;
    logic [12:0] addr;
  } pmaddr_drd_t;

endpackage

// ### verilog/pmaddr_stack.sv
`timescale 1ns/1ps
module pmaddr_stack
  import pmaddr_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   push_i,
  input  wire logic                   pop_i,
  input  wire logic [PMADDR_PC_W-1:0] push_data_i,
  output logic      [PMADDR_PC_W-1:0] top_o
);

  // ==========================================================================
  // Circular return stack
  // Overflow wraps and overwrites the oldest entry, as a real core does.
  logic [PMADDR_PC_W-1:0] mem_q [PMADDR_STACK_N];
  logic [PMADDR_SP_W-1:0] sp_q;
  wire  [PMADDR_SP_W-1:0] sp_up = sp_q + PMADDR_SP_ONE;
  wire  [PMADDR_SP_W-1:0] sp_dn = sp_q - PMADDR_SP_ONE;

  assign top_o = mem_q[sp_dn];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sp_q <= '0;
    end else if (push_i) begin
      mem_q[sp_q] <= push_data_i;
      sp_q        <= sp_up;
    end else if (pop_i) begin
      sp_q <= sp_dn;
    end
  end

endmodule

// ### verilog/pmaddr_top.sv
`timescale 1ns/1ps
module pmaddr_top
  import pmaddr_pkg::*;
(
  input  wire logic                     CLK_SYS_I,
  input  wire logic                     RSTN_I,
  input  wire pmaddr_ctrl_t             CTRL_I,
  input  wire pmaddr_drd_t              DATA_RD_I,
  input  wire logic [PMADDR_WORD_W-1:0] PROG_WORD_I,
  output logic      [PMADDR_IMPL_W-1:0] PROG_ADDR_O,
  output logic      [PMADDR_PC_W-1:0]   INSTR_PTR_O,
  output logic      [PMADDR_WORD_W-1:0] INSTR_O,
  output logic                          INSTR_VALID_O,
  output logic      [PMADDR_WORD_W-1:0] DATA_WORD_O,
  output logic                          DATA_VALID_O,
  output logic      [PMADDR_LIT_W-1:0]  WREG_LIT_O,
  output logic                          WREG_LIT_VALID_O
);

  // ==========================================================================
  // Instruction pointer next value
  // thirteen-bit pointer
  logic [PMADDR_PC_W-1:0] instruction_pointer_q;
  logic [PMADDR_PC_W-1:0] instruction_pointer_d;
  logic [PMADDR_PC_W-1:0] stack_top;
  logic                   fetch_q;
  logic                   data_phase_q;

  wire pmaddr_op_t op      = CTRL_I.op;
  wire logic       irq     = CTRL_I.irq_take;
  wire [PMADDR_PC_W-1:0] seq_addr = instruction_pointer_q + PMADDR_STEP;

  // ==========================================================================
  // Operation decode
  // An interrupt wins over whatever operation the core asked for in that cycle.
  wire op_call = !irq && (op == PMADDR_OP_CALL);
  wire op_ret  = !irq && (op == PMADDR_OP_RET);
  wire op_retl = !irq && (op == PMADDR_OP_RETL);
  wire do_push = irq | op_call;
  wire do_pop  = op_ret | op_retl;
  // The return address for an interrupt is the instruction not yet run.
  wire [PMADDR_PC_W-1:0] push_addr = irq ? instruction_pointer_q : seq_addr;
  // A data read steals the memory port for one cycle; that cycle's fetch is dropped, not delayed.
  wire data_rd = DATA_RD_I.rd_en;

  always_comb begin
    instruction_pointer_d = instruction_pointer_q;
    if (irq) begin
      instruction_pointer_d = PMADDR_INT_VEC;
    end else begin
      case (op)
        PMADDR_OP_HOLD: begin
          instruction_pointer_d = instruction_pointer_q;
        end
        PMADDR_OP_NEXT: begin
          instruction_pointer_d = seq_addr;
        end
        PMADDR_OP_JUMP: begin
          instruction_pointer_d = CTRL_I.target;
        end
        PMADDR_OP_CALL: begin
          instruction_pointer_d = CTRL_I.target;
        end
        PMADDR_OP_RET: begin
          instruction_pointer_d = stack_top;
        end
        PMADDR_OP_RETL: begin
          instruction_pointer_d = stack_top;
        end
        default: begin
          instruction_pointer_d = instruction_pointer_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // Return stack
  // A ninth nested call overwrites the oldest return address without warning,
  // so software must keep its nesting within eight levels.
  pmaddr_stack u_stack (
    .clk_i       (CLK_SYS_I),
    .rst_n_i     (RSTN_I),
    .push_i      (do_push),
    .pop_i       (do_pop),
    .push_data_i (push_addr),
    .top_o       (stack_top)
  );

  // ==========================================================================
  // Memory address fold
  // drop top bit
  wire [PMADDR_IMPL_W-1:0] fetch_addr = instruction_pointer_q[PMADDR_IMPL_W-1:0];
  wire [PMADDR_IMPL_W-1:0] data_addr  = DATA_RD_I.addr[PMADDR_IMPL_W-1:0];
  assign PROG_ADDR_O = data_rd ? data_addr : fetch_addr;
  assign INSTR_PTR_O = instruction_pointer_q;

  // ==========================================================================
  // Capture decode
  // A fetch slot is lost whenever a data read borrows the memory port.
  wire fetch_slot = !data_rd;
  wire lit_take   = op_retl;

  // ==========================================================================
  // Instruction pointer register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      instruction_pointer_q <= PMADDR_RESET_VEC;
    end else begin
      instruction_pointer_q <= instruction_pointer_d;
    end
  end

  // ==========================================================================
  // Memory phase tracking
  // The word comes back one edge after its address, so the kind of access
  // is remembered for exactly that one cycle.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= fetch_slot;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      data_phase_q <= 1'b0;
    end else begin
      data_phase_q <= data_rd;
    end
  end

  // ==========================================================================
  // Instruction capture
  // fourteen-bit word
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      INSTR_VALID_O <= 1'b0;
    end else begin
      INSTR_VALID_O <= fetch_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      INSTR_O <= '0;
    end else if (fetch_q) begin
      INSTR_O <= PROG_WORD_I;
    end
  end

  // ==========================================================================
  // Indirect data capture
  // indirect data
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      DATA_VALID_O <= 1'b0;
    end else begin
      DATA_VALID_O <= data_phase_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      DATA_WORD_O <= '0;
    end else if (data_phase_q) begin
      DATA_WORD_O <= PROG_WORD_I;
    end
  end

  // ==========================================================================
  // Literal capture
  // The literal travels with the return itself, so no memory cycle is spent.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      WREG_LIT_VALID_O <= 1'b0;
    end else begin
      WREG_LIT_VALID_O <= lit_take;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      WREG_LIT_O <= '0;
    end else if (lit_take) begin
      WREG_LIT_O <= CTRL_I.literal;
    end
  end

endmodule

// ### verif/pmaddr_properties.sv
`timescale 1ns/1ps
module pmaddr_properties
  import pmaddr_pkg::*;
(
  input wire logic         CLK_SYS_I,
  input wire logic         RSTN_I,
  input wire pmaddr_ctrl_t CTRL_I,
  input wire pmaddr_drd_t  DATA_RD_I,
  input wire logic [13:0]  PROG_WORD_I,
  input wire logic [11:0]  PROG_ADDR_O,
  input wire logic [12:0]  INSTR_PTR_O,
  input wire logic [13:0]  INSTR_O,
  input wire logic         INSTR_VALID_O,
  input wire logic [13:0]  DATA_WORD_O,
  input wire logic         DATA_VALID_O,
  input wire logic [7:0]   WREG_LIT_O,
  input wire logic         WREG_LIT_VALID_O
);
  // ==========================================================================
  // Properties
  wire logic       nq = !CTRL_I.irq_take;
  wire pmaddr_op_t op = CTRL_I.op;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  a_reset_vec: assert property ($rose(RSTN_I) |-> INSTR_PTR_O == 13'h0000)
    else $error("pointer not at reset entry");
  a_irq_vec: assert property (!nq |=> INSTR_PTR_O == 13'h0004)
    else $error("interrupt entry missed");
  a_seq_step: assert property (
    nq && op == PMADDR_OP_NEXT |=> INSTR_PTR_O == $past(INSTR_PTR_O) + 13'h1)
    else $error("pointer did not advance by one");
  a_jump_full: assert property (
    nq && op == PMADDR_OP_JUMP |=> INSTR_PTR_O == $past(CTRL_I.target))
    else $error("pointer lost target bits");
  a_data_word: assert property (DATA_VALID_O |-> DATA_WORD_O == $past(PROG_WORD_I))
    else $error("data word not captured");
  a_fetch_fold: assert property (!DATA_RD_I.rd_en |-> PROG_ADDR_O == INSTR_PTR_O[11:0])
    else $error("fetch address not folded");
  a_data_addr: assert property (DATA_RD_I.rd_en |-> PROG_ADDR_O == DATA_RD_I.addr[11:0])
    else $error("data read address wrong");
  a_word_whole: assert property (INSTR_VALID_O |-> INSTR_O == $past(PROG_WORD_I))
    else $error("fetched word not whole");
  a_call_ret: assert property (nq && op == PMADDR_OP_CALL ##1 nq && op == PMADDR_OP_RET
    |=> INSTR_PTR_O == $past(INSTR_PTR_O, 2) + 13'h1)
    else $error("return address wrong");
  a_lit_ret: assert property (nq && op == PMADDR_OP_RETL
    |=> WREG_LIT_VALID_O && WREG_LIT_O == $past(CTRL_I.literal))
    else $error("literal not returned");
endmodule

bind pmaddr_top pmaddr_properties chk_u (.CLK_SYS_I, .RSTN_I, .CTRL_I, .DATA_RD_I, .PROG_WORD_I,
  .PROG_ADDR_O, .INSTR_PTR_O, .INSTR_O, .INSTR_VALID_O, .DATA_WORD_O, .DATA_VALID_O,
  .WREG_LIT_O, .WREG_LIT_VALID_O);

// ### verif/pmaddr_top_test.sv
`timescale 1ns/1ps
module pmaddr_top_test
  import pmaddr_pkg::*;
;
  // ==========================================================================
  // Harness
  logic         CLK_SYS_I = 0, RSTN_I = 0, INSTR_VALID_O, DATA_VALID_O, WREG_LIT_VALID_O;
  pmaddr_ctrl_t CTRL_I = '0;
  pmaddr_drd_t  DATA_RD_I = '0;
  logic [13:0]  PROG_WORD_I = '0, INSTR_O, DATA_WORD_O;
  logic [11:0]  PROG_ADDR_O, pa [2];
  logic [12:0]  INSTR_PTR_O, ep, stk [8];
  logic [7:0]   WREG_LIT_O;
  logic [2:0]   sp = '0;
  logic [1:0]   pv = '0;
  int           d = 0, n_fail = 0, compares = 0;
  pmaddr_top dut_u (.CLK_SYS_I, .RSTN_I, .CTRL_I, .DATA_RD_I, .PROG_WORD_I, .PROG_ADDR_O,
    .INSTR_PTR_O, .INSTR_O, .INSTR_VALID_O, .DATA_WORD_O, .DATA_VALID_O, .WREG_LIT_O,
    .WREG_LIT_VALID_O);
  always #12.5 CLK_SYS_I = ~CLK_SYS_I;
  // The memory stand-in answers one cycle late, as the design expects.
  always @(posedge CLK_SYS_I) PROG_WORD_I <= #1 mem(PROG_ADDR_O);
  function logic [13:0] mem(input logic [11:0] a);
    return {a, 2'h1} ^ 14'h2a5c;
  endfunction
  task chk(input logic [13:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Underflow and overflow are steered away, since wrap order is not pinned down.
  task step(input pmaddr_op_t op, input logic irq, rd, input logic [12:0] t);
    if (op >= PMADDR_OP_RET && d == 0) op = PMADDR_OP_CALL;
    if (d == 8) op = PMADDR_OP_RET;
    if (d == 8) irq = 0;
    CTRL_I = '{op, irq, t, 8'($urandom)};
    DATA_RD_I = '{rd, 13'($urandom)};
    pa[1] = rd ? DATA_RD_I.addr[11:0] : ep[11:0];
    #1;
    chk(14'(PROG_ADDR_O), 14'(pa[1]));
    @(posedge CLK_SYS_I);
    #1;
    if (irq || op == PMADDR_OP_CALL) begin
      stk[sp] = irq ? ep : ep + PMADDR_STEP;
      sp++;
      d++;
    end else if (op >= PMADDR_OP_RET) begin
      sp--;
      d--;
    end
    ep = irq ? PMADDR_INT_VEC : op == PMADDR_OP_NEXT ? ep + PMADDR_STEP
       : op inside {PMADDR_OP_JUMP, PMADDR_OP_CALL} ? t : op >= PMADDR_OP_RET ? stk[sp] : ep;
    chk(14'(INSTR_PTR_O), 14'(ep));
    if (!irq && op == PMADDR_OP_RETL)
      chk(14'({WREG_LIT_VALID_O, WREG_LIT_O}), 14'({1'b1, CTRL_I.literal}));
    chk(14'(WREG_LIT_VALID_O), 14'(!irq && op == PMADDR_OP_RETL));
    if (pv[0]) chk(DATA_WORD_O, mem(pa[0]));
    chk(14'(DATA_VALID_O), 14'(pv[0]));
    if (pv[1]) chk(INSTR_O, mem(pa[0]));
    chk(14'(INSTR_VALID_O), 14'(pv[1]));
    pv = {!rd, rd};
    pa[0] = pa[1];
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(32'h810f));
    repeat (3) @(posedge CLK_SYS_I);
    #1;
    RSTN_I = 1;
    ep = '0;
    step(PMADDR_OP_JUMP, 0, 1, 13'h1fff);
    for (int i = 0; i < 14; i++)
      step(pmaddr_op_t'(i % 6), i > 11, i[0], 13'h0ff0 + 13'(i));
    for (int i = 0; i < 600; i++)
      step(pmaddr_op_t'($urandom % 6), $urandom % 8 == 0, $urandom % 3 == 0, 13'($urandom));
    RSTN_I = 0;
    @(posedge CLK_SYS_I);
    #1;
    chk(14'(INSTR_PTR_O), 14'(PMADDR_RESET_VEC));
    chk(14'({INSTR_VALID_O, DATA_VALID_O, WREG_LIT_VALID_O}), 14'h0);
    tally_and_finish;
  end
endmodule
